//--- common/bfp_pkg.sv
package bfp_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    localparam int IDX_LSB = 2;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_STAT = 6'h01;
    localparam logic [5:0] IDX_HDR_LEN = 6'h0B;
    localparam logic [5:0] IDX_HDR_PTR = 6'h0C;
    localparam logic [5:0] IDX_ERASE_AND_BUFFER_CAPS = 6'h30;
    localparam logic [5:0] IDX_SMALL_ERASE_OPCODE = 6'h31;
    localparam logic [5:0] IDX_READ_TYPE_SUPPORT = 6'h32;
    localparam logic [5:0] IDX_FIRST_WORD_UNUSED = 6'h33;
    localparam logic [5:0] IDX_DENSITY_BYTE0 = 6'h34;
    localparam logic [5:0] IDX_DENSITY_BYTE1 = 6'h35;
    localparam logic [5:0] IDX_DENSITY_BYTE2 = 6'h36;
    localparam logic [5:0] IDX_DENSITY_BYTE3 = 6'h37;
    localparam logic [5:0] IDX_QUAD_ADDR_READ_CYCLES = 6'h38;
    localparam logic [5:0] IDX_QUAD_ADDR_READ_OPCODE = 6'h39;
    localparam logic [5:0] IDX_QUAD_OUT_READ_CYCLES = 6'h3A;
    localparam logic [5:0] IDX_QUAD_OUT_READ_OPCODE = 6'h3B;
    localparam logic [5:0] IDX_DUAL_OUT_READ_CYCLES = 6'h3C;
    localparam logic [5:0] IDX_DUAL_OUT_READ_OPCODE = 6'h3D;
    localparam logic [5:0] IDX_DUAL_ADDR_READ_CYCLES = 6'h3E;
    localparam logic [5:0] IDX_DUAL_ADDR_READ_OPCODE = 6'h3F;

    // Fixed table contents
    localparam logic [7:0] VAL_HDR_LEN = 8'h10;
    localparam logic [7:0] VAL_HDR_PTR = 8'h30;
    localparam logic [7:0] VAL_ERASE_AND_BUFFER_CAPS = 8'hE5;
    localparam logic [7:0] VAL_SMALL_ERASE_OPCODE = 8'h20;
    localparam logic [7:0] VAL_READ_TYPE_SUPPORT = 8'hF1;
    localparam logic [7:0] VAL_FIRST_WORD_UNUSED = 8'hFF;
    localparam logic [7:0] VAL_DENSITY_BYTE0 = 8'hFF;
    localparam logic [7:0] VAL_DENSITY_BYTE1 = 8'hFF;
    localparam logic [7:0] VAL_DENSITY_BYTE2 = 8'h7F;
    localparam logic [7:0] VAL_DENSITY_BYTE3 = 8'h00;
    localparam logic [7:0] VAL_QUAD_ADDR_READ_CYCLES = 8'h44;
    localparam logic [7:0] VAL_QUAD_ADDR_READ_OPCODE = 8'hEB;
    localparam logic [7:0] VAL_QUAD_OUT_READ_CYCLES = 8'h08;
    localparam logic [7:0] VAL_QUAD_OUT_READ_OPCODE = 8'h6B;
    localparam logic [7:0] VAL_DUAL_OUT_READ_CYCLES = 8'h08;
    localparam logic [7:0] VAL_DUAL_OUT_READ_OPCODE = 8'h3B;
    localparam logic [7:0] VAL_DUAL_ADDR_READ_CYCLES = 8'h80;
    localparam logic [7:0] VAL_DUAL_ADDR_READ_OPCODE = 8'hBB;

    // Control and status fields
    localparam int CTRL_STRICT_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam logic [7:0] REFUSED_MAX = 8'hFF;
    localparam logic [7:0] REFUSED_ONE = 8'h01;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } bfp_wb_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] dat;
    } bfp_wb_rsp_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] dat;
        logic strict;
        logic [7:0] refused;
    } bfp_state_t;

    localparam bfp_state_t STATE_RST = '{
        ack: 1'b0,
        err: 1'b0,
        dat: 32'h0000_0000,
        strict: 1'b0,
        refused: 8'h00
    };

endpackage

//--- hdl/bfp_table.sv
`timescale 1ns/100ps

// Operation
// - Byte 30h reads E5h: uniform 4 kB erase available everywhere.
// - Byte 30h bit 2 is one: program buffer exceeds 64 bytes.
// - Byte 30h bits 4:3 are 00b: status register non-volatile by default.
// - Byte 31h reads 20h, the uniform 4 kB erase opcode.
// - Byte 32h reads F1h: read types supported, three-byte addressing, no DDR.
// - Byte 33h is unused and always reads FFh.
// - Bytes 34h-37h give density 007FFFFFh little-endian: FF FF 7F 00.
// - Byte 38h reads 44h: quad address-data read mode and dummy cycles.
// - Byte 39h reads EBh, the quad address-data read opcode.
// - Byte 3Ah reads 08h: quad output read, zero mode, eight dummy.
// - Byte 3Bh reads 6Bh, the quad output read opcode.
// - Byte 3Ch reads 08h: dual output read, zero mode, eight dummy.
// - Byte 3Dh reads 3Bh, the dual output read opcode.
// - Byte 3Eh reads 80h: dual address-data read, four mode, zero dummy.
// - Byte 3Fh reads BBh, the dual address-data read opcode.
// - Header pointer at 0Ch reads 30h, locating the parameter table.
// - Header length at 0Bh reads 10h, sixteen doublewords.
module bfp_table (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Wishbone slave
    input wire bfp_pkg::bfp_wb_req_t wb_req,
    output bfp_pkg::bfp_wb_rsp_t wb_rsp
);

    bfp_pkg::bfp_state_t s_reg;
    bfp_pkg::bfp_state_t s_next;
    logic req;
    logic [5:0] idx;
    logic [8:0] entry;

    // Returns {hit, byte}; constants only, so contents cannot drift
    function automatic logic [8:0] table_entry(input logic [5:0] i);
        logic [8:0] r;
        r = 9'h000;
        case (i)
            bfp_pkg::IDX_HDR_LEN: r = {1'b1, bfp_pkg::VAL_HDR_LEN};
            bfp_pkg::IDX_HDR_PTR: r = {1'b1, bfp_pkg::VAL_HDR_PTR};
            bfp_pkg::IDX_ERASE_AND_BUFFER_CAPS: begin
                r = {1'b1, bfp_pkg::VAL_ERASE_AND_BUFFER_CAPS};
            end
            bfp_pkg::IDX_SMALL_ERASE_OPCODE: begin
                r = {1'b1, bfp_pkg::VAL_SMALL_ERASE_OPCODE};
            end
            bfp_pkg::IDX_READ_TYPE_SUPPORT: r = {1'b1, bfp_pkg::VAL_READ_TYPE_SUPPORT};
            bfp_pkg::IDX_FIRST_WORD_UNUSED: r = {1'b1, bfp_pkg::VAL_FIRST_WORD_UNUSED};
            bfp_pkg::IDX_DENSITY_BYTE0: r = {1'b1, bfp_pkg::VAL_DENSITY_BYTE0};
            bfp_pkg::IDX_DENSITY_BYTE1: r = {1'b1, bfp_pkg::VAL_DENSITY_BYTE1};
            bfp_pkg::IDX_DENSITY_BYTE2: r = {1'b1, bfp_pkg::VAL_DENSITY_BYTE2};
            bfp_pkg::IDX_DENSITY_BYTE3: r = {1'b1, bfp_pkg::VAL_DENSITY_BYTE3};
            bfp_pkg::IDX_QUAD_ADDR_READ_CYCLES: begin
                r = {1'b1, bfp_pkg::VAL_QUAD_ADDR_READ_CYCLES};
            end
            bfp_pkg::IDX_QUAD_ADDR_READ_OPCODE: begin
                r = {1'b1, bfp_pkg::VAL_QUAD_ADDR_READ_OPCODE};
            end
            bfp_pkg::IDX_QUAD_OUT_READ_CYCLES: begin
                r = {1'b1, bfp_pkg::VAL_QUAD_OUT_READ_CYCLES};
            end
            bfp_pkg::IDX_QUAD_OUT_READ_OPCODE: begin
                r = {1'b1, bfp_pkg::VAL_QUAD_OUT_READ_OPCODE};
            end
            bfp_pkg::IDX_DUAL_OUT_READ_CYCLES: begin
                r = {1'b1, bfp_pkg::VAL_DUAL_OUT_READ_CYCLES};
            end
            bfp_pkg::IDX_DUAL_OUT_READ_OPCODE: begin
                r = {1'b1, bfp_pkg::VAL_DUAL_OUT_READ_OPCODE};
            end
            bfp_pkg::IDX_DUAL_ADDR_READ_CYCLES: begin
                r = {1'b1, bfp_pkg::VAL_DUAL_ADDR_READ_CYCLES};
            end
            bfp_pkg::IDX_DUAL_ADDR_READ_OPCODE: begin
                r = {1'b1, bfp_pkg::VAL_DUAL_ADDR_READ_OPCODE};
            end
            default: r = 9'h000;
        endcase
        return r;
    endfunction

    // Back-to-back cycles are answered every other clock
    assign req = wb_req.cyc && wb_req.stb && !s_reg.ack && !s_reg.err;
    assign idx = wb_req.adr[bfp_pkg::IDX_LSB +: bfp_pkg::IDX_W];
    assign entry = table_entry(idx);

    always_comb begin
        s_next = s_reg;
        s_next.ack = 1'b0;
        s_next.err = 1'b0;
        if (req) begin
            s_next.dat = 32'h0000_0000;
            if (idx == bfp_pkg::IDX_CTRL) begin
                s_next.ack = 1'b1;
                if (wb_req.we) begin
                    if (wb_req.sel[0]) begin
                        s_next.strict = wb_req.dat[bfp_pkg::CTRL_STRICT_BIT];
                        if (wb_req.dat[bfp_pkg::CTRL_CLEAR_BIT]) begin
                            s_next.refused = 8'h00;
                        end
                    end
                end else begin
                    s_next.dat[bfp_pkg::CTRL_STRICT_BIT] = s_reg.strict;
                end
            end else if (entry[8] || idx == bfp_pkg::IDX_STAT) begin
                if (wb_req.we) begin
                    // Write dropped; contents never change
                    s_next.ack = !s_reg.strict;
                    s_next.err = s_reg.strict;
                    if (s_reg.refused != bfp_pkg::REFUSED_MAX) begin
                        s_next.refused = s_reg.refused + bfp_pkg::REFUSED_ONE;
                    end
                end else begin
                    s_next.ack = 1'b1;
                    s_next.dat[7:0] = (idx == bfp_pkg::IDX_STAT) ? s_reg.refused : entry[7:0];
                end
            end else begin
                // Unmapped index
                s_next.err = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_reg <= bfp_pkg::STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_rsp.ack = s_reg.ack;
    assign wb_rsp.err = s_reg.err;
    assign wb_rsp.dat = s_reg.dat;

    chk_answer_next_cycle: assert property (
        @(posedge sys_clk) disable iff (srst)
        req |=> (wb_rsp.ack || wb_rsp.err)
    ) else $error("request not answered in the next cycle");

    chk_answer_single_pulse: assert property (
        @(posedge sys_clk) disable iff (srst)
        (wb_rsp.ack || wb_rsp.err) |=> !(wb_rsp.ack || wb_rsp.err)
    ) else $error("answer held longer than one cycle");

    chk_caps_byte: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == 6'h30) |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_00E5)
    ) else $error("capability byte wrong");

    chk_caps_fields: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == 6'h30) |=> (wb_rsp.dat[2] && wb_rsp.dat[4:3] == 2'b00)
    ) else $error("buffer or status volatility field wrong");

    chk_read_support: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == 6'h32) |=> (wb_rsp.dat == 32'h0000_00F1)
    ) else $error("read support byte wrong");

    chk_density_top: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == 6'h36) |=> (wb_rsp.dat == 32'h0000_007F)
    ) else $error("density byte two wrong");

    chk_quad_cycles: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == 6'h38)
            |=> (wb_rsp.dat[7:5] == 3'b010 && wb_rsp.dat[4:0] == 5'b00100)
    ) else $error("quad address-data cycle byte wrong");

    chk_dual_cycles: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == 6'h3E) |=> (wb_rsp.dat == 32'h0000_0080)
    ) else $error("dual address-data cycle byte wrong");

    chk_header_pointer: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == 6'h0C) |=> (wb_rsp.dat == 32'h0000_0030)
    ) else $error("header pointer wrong");

    chk_header_length: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == 6'h0B) |=> (wb_rsp.dat == 32'h0000_0010)
    ) else $error("header length wrong");

    chk_refused_write: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && wb_req.we && entry[8] && s_reg.strict) |=> (wb_rsp.err && !wb_rsp.ack)
    ) else $error("strict mode write to table not refused");

    chk_caps_erase_bits: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_ERASE_AND_BUFFER_CAPS)
            |=> (wb_rsp.ack && wb_rsp.dat[7:5] == 3'b111 && wb_rsp.dat[1:0] == 2'b01)
    ) else $error("uniform erase field wrong");

    chk_caps_status_bits: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_ERASE_AND_BUFFER_CAPS)
            |=> (wb_rsp.ack && wb_rsp.dat[4:3] == 2'b00)
    ) else $error("status volatility field wrong");

    chk_erase_opcode: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_SMALL_ERASE_OPCODE)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_0020)
    ) else $error("erase opcode byte wrong");

    chk_read_fields: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_READ_TYPE_SUPPORT)
            |=> (wb_rsp.dat[7:4] == 4'b1111 && wb_rsp.dat[3:1] == 3'b000 && wb_rsp.dat[0])
    ) else $error("read support fields wrong");

    chk_unused_byte: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_FIRST_WORD_UNUSED)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_00FF)
    ) else $error("unused byte not all ones");

    chk_density_low: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_DENSITY_BYTE0)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_00FF)
    ) else $error("density byte zero wrong");

    chk_density_mid: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_DENSITY_BYTE1)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_00FF)
    ) else $error("density byte one wrong");

    chk_density_high: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_DENSITY_BYTE3)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_0000)
    ) else $error("density byte three wrong");

    chk_quad_cycles_byte: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_QUAD_ADDR_READ_CYCLES)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_0044)
    ) else $error("quad address-data cycle byte value wrong");

    chk_quad_addr_opcode: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_QUAD_ADDR_READ_OPCODE)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_00EB)
    ) else $error("quad address-data opcode wrong");

    chk_quad_out_cycles: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_QUAD_OUT_READ_CYCLES)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_0008)
    ) else $error("quad output cycle byte wrong");

    chk_quad_out_opcode: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_QUAD_OUT_READ_OPCODE)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_006B)
    ) else $error("quad output opcode wrong");

    chk_dual_out_cycles: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_DUAL_OUT_READ_CYCLES)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_0008)
    ) else $error("dual output cycle byte wrong");

    chk_dual_out_opcode: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_DUAL_OUT_READ_OPCODE)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_003B)
    ) else $error("dual output opcode wrong");

    chk_dual_addr_opcode: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_DUAL_ADDR_READ_OPCODE)
            |=> (wb_rsp.ack && wb_rsp.dat == 32'h0000_00BB)
    ) else $error("dual address-data opcode wrong");

    chk_upper_bits_zero: assert property (
        @(posedge sys_clk) disable iff (srst)
        wb_rsp.ack
            |-> wb_rsp.dat[31:8] == '0
    ) else $error("read data upper bits not zero");

    chk_err_data_zero: assert property (
        @(posedge sys_clk) disable iff (srst)
        wb_rsp.err
            |-> wb_rsp.dat == '0
    ) else $error("error answer carries data");

    chk_ack_err_exclusive: assert property (
        @(posedge sys_clk) disable iff (srst)
        wb_rsp.ack
            |-> !wb_rsp.err
    ) else $error("ack and err raised together");

    chk_idle_no_answer: assert property (
        @(posedge sys_clk) disable iff (srst)
        !req
            |=> !(wb_rsp.ack || wb_rsp.err)
    ) else $error("answer without a request");

    chk_lenient_write_ack: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && wb_req.we && entry[8] && !s_reg.strict)
            |=> (wb_rsp.ack && !wb_rsp.err)
    ) else $error("lenient table write not acknowledged");

    chk_unmapped_err: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !entry[8] && idx != bfp_pkg::IDX_CTRL && idx != bfp_pkg::IDX_STAT)
            |=> (wb_rsp.err && !wb_rsp.ack && wb_rsp.dat == '0)
    ) else $error("unmapped index not refused");

    chk_refused_count_step: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && wb_req.we && entry[8] && s_reg.refused != 8'hFF)
            |=> s_reg.refused == $past(s_reg.refused) + 8'h01
    ) else $error("refused write not counted");

    chk_refused_saturate: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && wb_req.we && entry[8] && s_reg.refused == 8'hFF)
            |=> s_reg.refused == 8'hFF
    ) else $error("refused count wrapped");

    chk_refused_clear: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && wb_req.we && idx == bfp_pkg::IDX_CTRL && wb_req.sel[0]
            && wb_req.dat[bfp_pkg::CTRL_CLEAR_BIT]) |=> s_reg.refused == 8'h00
    ) else $error("refused count not cleared");

    chk_strict_follows_write: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && wb_req.we && idx == bfp_pkg::IDX_CTRL && wb_req.sel[0])
            |=> s_reg.strict == $past(wb_req.dat[bfp_pkg::CTRL_STRICT_BIT])
    ) else $error("strict bit not taken from write");

    chk_strict_held: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && wb_req.we && idx == bfp_pkg::IDX_CTRL && !wb_req.sel[0])
            |=> $stable(s_reg.strict)
    ) else $error("strict bit changed without byte enable");

    chk_ctrl_read: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_CTRL)
            |=> (wb_rsp.dat[31:1] == '0 && wb_rsp.dat[0] == $past(s_reg.strict))
    ) else $error("control read wrong");

    chk_stat_read: assert property (
        @(posedge sys_clk) disable iff (srst)
        (req && !wb_req.we && idx == bfp_pkg::IDX_STAT)
            |=> (wb_rsp.ack && wb_rsp.dat[7:0] == $past(s_reg.refused))
    ) else $error("status read wrong");

    chk_count_only_on_write: assert property (
        @(posedge sys_clk) disable iff (srst)
        !(req && wb_req.we)
            |=> $stable(s_reg.refused)
    ) else $error("refused count moved without a write");

    chk_reset_clears: assert property (
        @(posedge sys_clk)
        srst |=> (!wb_rsp.ack && !wb_rsp.err && wb_rsp.dat == '0
            && !s_reg.strict && s_reg.refused == 8'h00)
    ) else $error("reset left state behind");

    chk_dat_holds: assert property (
        @(posedge sys_clk) disable iff (srst)
        !req
            |=> $stable(wb_rsp.dat)
    ) else $error("read data changed without a request");

endmodule

//--- dv/bfp_host.sv
`timescale 1ns/100ps

module bfp_host (
    // Clock
    input wire logic sys_clk,
    // Wishbone master
    output bfp_pkg::bfp_wb_req_t wb_req,
    input wire bfp_pkg::bfp_wb_rsp_t wb_rsp
);
    initial begin
        wb_req = '0;
    end

    // Classic cycle; answer is {err, dat}; only the bench watchdog ends a wait
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                        output logic [32:0] rsp, input logic [3:0] be = 4'h1);
        @(posedge sys_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: be, dat: wdat};
        do begin
            @(posedge sys_clk);
        end while (wb_rsp.ack !== 1'b1 && wb_rsp.err !== 1'b1);
        rsp = {wb_rsp.err, wb_rsp.dat};
        // Write data inverted on release so a late sample shows garbage
        wb_req <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~wdat};
    endtask
endmodule

//--- dv/test_basic_flash_param_table.sv
`timescale 1ns/100ps

module test_basic_flash_param_table;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    bfp_pkg::bfp_wb_req_t wb_req;
    bfp_pkg::bfp_wb_rsp_t wb_rsp;
    int fail_count = 0;
    int checked = 0;
    logic [32:0] r;
    logic [7:0] base;
    logic [7:0] exp_tab [16] = '{8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h00,
                                 8'h44, 8'hEB, 8'h08, 8'h6B, 8'h08, 8'h3B, 8'h80, 8'hBB};

    always #12.5 sys_clk = ~sys_clk;

    bfp_table DUT (
        .sys_clk(sys_clk),
        .srst(srst),
        .wb_req(wb_req),
        .wb_rsp(wb_rsp)
    );

    bfp_host host (
        .sys_clk(sys_clk),
        .wb_req(wb_req),
        .wb_rsp(wb_rsp)
    );

    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Whole table through the pointer, back to back
    task automatic read_table();
        logic [32:0] t;
        for (int i = 0; i < 16; i++) begin
            host.xfer(1'b0, (base + 8'(i)) << 2, 32'h0, t);
            chk("table byte", {25'h0, exp_tab[i]}, t);
            chk("table byte", {25'h0, exp_tab[i]}, t);
            chk("table read err", 33'h0, {t[32], 32'h0});
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #(25 * 4000);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        host.xfer(1'b0, 8'h30, 32'h0, r);
        chk("header pointer", 33'h0_0000_0030, r);
        base = r[7:0];
        host.xfer(1'b0, 8'h2C, 32'h0, r);
        chk("header length", 33'h0_0000_0010, r);
        read_table();
        // Lenient writes are answered with ack and leave the table alone
        for (int i = 0; i < 16; i++) begin
            host.xfer(1'b1, (base + 8'(i)) << 2, 32'h0000_005A, r);
            chk("table write err", 33'h0, {r[32], 32'h0});
        end
        read_table();
        host.xfer(1'b0, 8'h04, 32'h0, r);
        chk("refused count", 33'h0_0000_0010, r);
        // Control write without its byte enable is ignored
        host.xfer(1'b1, 8'h00, 32'h0000_0001, r, 4'h0);
        host.xfer(1'b0, 8'h00, 32'h0, r);
        chk("strict without sel", 33'h0_0000_0000, r);
        // Strict mode turns a table write into err
        host.xfer(1'b1, 8'h00, 32'h0000_0001, r);
        host.xfer(1'b1, 8'hC0, 32'h0000_0000, r);
        chk("strict write err", 33'h1_0000_0000, {r[32], 32'h0});
        host.xfer(1'b0, 8'hC0, 32'h0, r);
        chk("byte after write", 33'h0_0000_00E5, r);
        host.xfer(1'b1, 8'h2C, 32'h0000_0000, r);
        host.xfer(1'b0, 8'h2C, 32'h0, r);
        chk("length after write", 33'h0_0000_0010, r);
        host.xfer(1'b0, 8'h04, 32'h0, r);
        chk("refused count", 33'h0_0000_0012, r);
        host.xfer(1'b1, 8'h00, 32'h0000_0002, r);
        host.xfer(1'b0, 8'h04, 32'h0, r);
        chk("cleared count", 33'h0_0000_0000, r);
        host.xfer(1'b0, 8'h08, 32'h0, r);
        chk("unmapped read", 33'h1_0000_0000, r);
        // Count saturates rather than wrapping
        repeat (256) host.xfer(1'b1, 8'hFC, 32'h0, r);
        host.xfer(1'b0, 8'h04, 32'h0, r);
        chk("saturated count", 33'h0_0000_00FF, r);
        // Second reset mid-run with strict set and a count pending
        host.xfer(1'b1, 8'h00, 32'h0000_0001, r);
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        host.xfer(1'b0, 8'h00, 32'h0, r);
        chk("control after reset", 33'h0_0000_0000, r);
        host.xfer(1'b0, 8'h04, 32'h0, r);
        chk("count after reset", 33'h0_0000_0000, r);
        read_table();
        print_verdict();
    end
endmodule
